// ===== rtl/pfi_irq_ctrl.sv
// Interrupt and protection event logic of a dual switcher, dual linear PMIC.
// Assumes analog indications arrive asynchronously and a host on a plain register port.
`timescale 1ns/100ps
module pfi_irq_ctrl
   import pfi_pkg::*;
#(
   parameter int SHORT_CYCLES = SHORT_CYC
)(
   // Clock and reset
   input  wire logic          clock_i,
   input  wire logic          rst_i,
   // Register port
   input  wire pfi_bus_s      bus_i,
   output logic [DW-1:0]      rdata_o,
   // Analog indications and OTP
   input  wire pfi_analog_s   analog_i,
   input  wire logic          otp_reset_mask_i,
   // Device outputs
   output logic               irq_line_n_o,
   output logic [3:0]         reg_enable_o,
   output logic               general_output_a_o,
   output logic               general_output_b_o,
   output logic               power_ok_pin_o
);
   localparam int CW = $clog2(SHORT_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SHORT_CYCLES - 1);

   pfi_analog_s s1, s2, s3, f, fq;
   pfi_state_e  state;
   logic        run, wr, swr, det_en, pol, ok_state, ok_q;
   logic [3:0]  en, low, ilim, pg, pg_q, pg_rise, pg_fall, sc_evt;
   logic [3:0]  oc_flag, sc_flag, pg_flag, pg_arm;
   logic [3:0]  oc_mask, rise_mask, fall_mask;
   logic [6:0]  top_flag, top_mask, top_set, clr_top;
   logic [1:0]  general_output_a;
   logic [5:0]  clr_sw, clr_ln;
   logic [3:0]  clr_oc, clr_sc, clr_pg;
   logic        sum_sw, sum_ln, pend;
   logic [CW-1:0] cnt [4];

   // Three stages; a change is taken once the last two agree
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         f  <= '0;
         fq <= '0;
      end else begin
         s1 <= analog_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            f <= s3;
         end
         fq <= f;
      end
   end

   assign low     = {f.ln_low, f.sw_low};
   assign ilim    = {f.ln_ilim, f.sw_ilim};
   assign pg      = {f.ln_pg, f.sw_pg};
   assign pg_q    = {fq.ln_pg, fq.sw_pg};
   assign pg_rise = pg & ~pg_q;
   assign pg_fall = ~pg & pg_q;
   assign run     = (state == ST_RUN);
   assign wr      = bus_i.wr & run;
   assign swr     = wr && (bus_i.addr == ADDR_RESET) && bus_i.wdata[0];

   // Start-up sequencer; power-on reset behaves as leaving undervoltage
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_OFF;
      end else begin
         case (state)
            ST_OFF: begin
               if (!f.uvlo) begin
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               state <= ST_RUN;
            end
            ST_RUN: begin
               if (f.uvlo || swr) begin
                  state <= ST_OFF;
               end
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   // Short detection: low output while enabled for the full debounce
   for (genvar i = 0; i < 4; i++) begin : g_short
      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            cnt[i] <= '0;
         end else if (en[i] && low[i]) begin
            cnt[i] <= cnt[i] + 1'b1;
         end else begin
            cnt[i] <= '0;
         end
      end
      assign sc_evt[i] = run && en[i] && low[i] && (cnt[i] == LAST);
   end

   // Write-one-to-clear strobes
   assign clr_top = (wr && bus_i.addr == ADDR_FLAG_TOP) ? bus_i.wdata[6:0] : '0;
   assign clr_sw  = (wr && bus_i.addr == ADDR_FLAG_SW) ? bus_i.wdata[5:0] : '0;
   assign clr_ln  = (wr && bus_i.addr == ADDR_FLAG_LN) ? bus_i.wdata[5:0] : '0;
   assign clr_oc  = {clr_ln[1:0], clr_sw[1:0]};
   assign clr_sc  = {clr_ln[3:2], clr_sw[3:2]};
   assign clr_pg  = {clr_ln[5:4], clr_sw[5:4]};

   // Top-level events
   always_comb begin
      top_set          = '0;
      top_set[B_HOT]   = f.hot_warn;
      top_set[B_HEAT]  = f.overheat;
      top_set[B_OVV]   = f.overvolt;
      top_set[B_OKDROP] = ok_q && !ok_state;
      top_set[B_SYNC]  = det_en && (f.ext_clk != fq.ext_clk);
      top_set[B_MEAS]  = f.meas_done && !fq.meas_done;
   end

   // Flags: level conditions re-set every cycle, so a clear cannot win while active
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         top_flag <= '0;
         oc_flag  <= '0;
         sc_flag  <= '0;
         pg_flag  <= '0;
         pg_arm   <= '0;
      end else if (state == ST_OFF) begin
         top_flag <= '0;
         oc_flag  <= '0;
         sc_flag  <= '0;
         pg_flag  <= '0;
         pg_arm   <= '0;
      end else if (state == ST_LOAD) begin
         top_flag[B_RST] <= !otp_reset_mask_i;
      end else begin
         top_flag <= top_set | (top_flag & ~clr_top);
         oc_flag  <= ilim | (oc_flag & ~clr_oc);
         sc_flag  <= sc_evt | (sc_flag & ~clr_sc);
         pg_flag  <= pg_rise | pg_fall | (pg_flag & ~clr_pg);
         pg_arm   <= (pg_rise & ~rise_mask) | (pg_fall & ~fall_mask) | (pg_arm & ~clr_pg);
      end
   end

   // Detector enable while the clock is absent counts as a disappearance
   logic det_q;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         det_q <= 1'b0;
      end else begin
         det_q <= det_en;
      end
   end
   logic miss_evt;
   assign miss_evt = det_en && !det_q && !f.ext_clk;

   // The sync flag also takes the missing-clock event
   logic sync_extra;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sync_extra <= 1'b0;
      end else if (!run) begin
         sync_extra <= 1'b0;
      end else begin
         sync_extra <= miss_evt | (sync_extra & ~clr_top[B_SYNC]);
      end
   end

   // Masks; the reset mask bit only follows OTP
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         top_mask <= TOP_MASK_RST;
         oc_mask  <= '0;
         rise_mask <= '0;
         fall_mask <= '0;
      end else if (state == ST_OFF) begin
         top_mask <= TOP_MASK_RST;
         oc_mask  <= '0;
         rise_mask <= '0;
         fall_mask <= '0;
      end else if (state == ST_LOAD) begin
         top_mask[B_RST] <= otp_reset_mask_i;
      end else if (wr) begin
         if (bus_i.addr == ADDR_MASK_TOP) begin
            top_mask <= (bus_i.wdata[6:0] & TOP_MASK_WR) | (top_mask & ~TOP_MASK_WR);
         end
         if (bus_i.addr == ADDR_MASK_SW) begin
            oc_mask[1:0]   <= bus_i.wdata[1:0];
            rise_mask[1:0] <= bus_i.wdata[3:2];
            fall_mask[1:0] <= bus_i.wdata[5:4];
         end
         if (bus_i.addr == ADDR_MASK_LN) begin
            oc_mask[3:2]   <= bus_i.wdata[1:0];
            rise_mask[3:2] <= bus_i.wdata[3:2];
            fall_mask[3:2] <= bus_i.wdata[5:4];
         end
      end
   end

   // Control: regulator enables, general outputs, polarity, detector
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         en     <= CTRL_RST[3:0];
         general_output_a    <= CTRL_RST[B_GPOB:B_GPOA];
         pol    <= CTRL_RST[B_POL];
         det_en <= CTRL_RST[B_DET];
      end else if (state != ST_RUN) begin
         en     <= CTRL_RST[3:0];
         general_output_a    <= CTRL_RST[B_GPOB:B_GPOA];
         pol    <= CTRL_RST[B_POL];
         det_en <= CTRL_RST[B_DET];
      end else if (f.overheat || f.overvolt) begin
         en  <= '0;
         general_output_a <= '0;
      end else begin
         if (wr && bus_i.addr == ADDR_CTRL) begin
            en     <= bus_i.wdata[3:0] & ~sc_evt;
            general_output_a    <= bus_i.wdata[B_GPOB:B_GPOA];
            pol    <= bus_i.wdata[B_POL];
            det_en <= bus_i.wdata[B_DET];
         end else begin
            en <= en & ~sc_evt;
         end
      end
   end

   // Group summaries and interrupt line
   assign sum_sw = |{oc_flag[1:0], sc_flag[1:0], pg_flag[1:0]};
   assign sum_ln = |{oc_flag[3:2], sc_flag[3:2], pg_flag[3:2]};
   assign pend = |(top_flag & ~top_mask) | (sync_extra & ~top_mask[B_SYNC]) |
                 |(oc_flag & ~oc_mask) | |sc_flag | |pg_arm;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         irq_line_n_o <= 1'b1;
      end else begin
         irq_line_n_o <= !pend;
      end
   end

   // Power-ok state is polarity-free; only the pin is inverted
   assign ok_state = run && f.volts_ok;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ok_q           <= 1'b0;
         power_ok_pin_o <= 1'b0;
      end else begin
         ok_q           <= ok_state;
         power_ok_pin_o <= ok_state ^ pol;
      end
   end

   assign reg_enable_o       = en;
   assign general_output_a_o = general_output_a[0];
   assign general_output_b_o = general_output_a[1];

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (!bus_i.rd) begin
         rdata_o <= '0;
      end else begin
         case (bus_i.addr)
            ADDR_FLAG_TOP:  rdata_o <= {1'b0, top_flag | {2'b00, sync_extra, 4'h0}};
            ADDR_FLAG_SW:   rdata_o <= {2'b00, pg_flag[1:0], sc_flag[1:0], oc_flag[1:0]};
            ADDR_FLAG_LN:   rdata_o <= {2'b00, pg_flag[3:2], sc_flag[3:2], oc_flag[3:2]};
            ADDR_MASK_TOP:  rdata_o <= {1'b0, top_mask};
            ADDR_MASK_SW:   rdata_o <= {2'b00, fall_mask[1:0], rise_mask[1:0], oc_mask[1:0]};
            ADDR_MASK_LN:   rdata_o <= {2'b00, fall_mask[3:2], rise_mask[3:2], oc_mask[3:2]};
            ADDR_STATE_TOP: rdata_o <= {sum_ln, sum_sw, 1'b0, f.ext_clk, ok_state, f.overvolt,
                                        f.overheat, f.hot_warn};
            ADDR_STATE_SW:  rdata_o <= {4'h0, f.sw_pg, f.sw_ilim};
            ADDR_STATE_LN:  rdata_o <= {4'h0, f.ln_pg, f.ln_ilim};
            ADDR_CTRL:      rdata_o <= {det_en, pol, general_output_a, en};
            default:        rdata_o <= '0;
         endcase
      end
   end

   // Checks
   property p_irq_set;
      @(posedge clock_i) disable iff (rst_i)
      (run && !f.uvlo && !swr && f.overheat) |-> ##2 !irq_line_n_o;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq not low after overheat");

   property p_irq_release;
      @(posedge clock_i) disable iff (rst_i)
      !pend |=> irq_line_n_o;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("irq low with nothing pending");

   property p_reset_flag;
      @(posedge clock_i) disable iff (rst_i)
      (state == ST_LOAD && !otp_reset_mask_i) |=> (top_flag[B_RST] && run);
   endproperty
   a_reset_flag: assert property (p_reset_flag) else $error("reset flag missing after start-up");

   property p_mask_fixed;
      @(posedge clock_i) disable iff (rst_i)
      (wr && bus_i.addr == ADDR_MASK_TOP) |=> $stable(top_mask[B_RST]);
   endproperty
   a_mask_fixed: assert property (p_mask_fixed) else $error("reset mask changed by write");

   property p_oc_hold;
      @(posedge clock_i) disable iff (rst_i)
      (run && !f.uvlo && !swr && f.sw_ilim[0] && clr_oc[0]) |=> oc_flag[0];
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag cleared while active");

   property p_short;
      @(posedge clock_i) disable iff (rst_i)
      sc_evt[0] |-> ($past(cnt[0]) == LAST - 1'b1) ##1 (!en[0] && sc_flag[0]);
   endproperty
   a_short: assert property (p_short) else $error("short not acted on");

   property p_heat_off;
      @(posedge clock_i) disable iff (rst_i)
      f.overheat |=> (en == '0) && !general_output_a_o && !general_output_b_o;
   endproperty
   a_heat_off: assert property (p_heat_off) else $error("overheat left outputs on");

   property p_pin_pol;
      @(posedge clock_i) disable iff (rst_i)
      run |=> power_ok_pin_o == ($past(f.volts_ok) ^ $past(pol));
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("power-ok pin polarity wrong");

   property p_masked;
      @(posedge clock_i) disable iff (rst_i)
      (pend == 1'b0 && oc_flag != '0) |=> irq_line_n_o;
   endproperty
   a_masked: assert property (p_masked) else $error("masked flag drove irq");

   property p_uvlo_off;
      @(posedge clock_i) disable iff (rst_i)
      (run && f.uvlo) |=> !run ##1 (top_flag == '0 && en == '0);
   endproperty
   a_uvlo_off: assert property (p_uvlo_off) else $error("undervoltage left flags or enables");
endmodule

// ===== common/pfi_pkg.sv
// Package for the power-fault interrupt logic: register map, timing, carriers.
// Assumes a single 40 MHz clock domain.
package pfi_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SHORT_TIME_NS = 1000000;
   // Least time, rounded up to whole cycles
   localparam int SHORT_CYC     = (SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int AW = 4;
   localparam int DW = 8;

   localparam logic [AW-1:0] ADDR_FLAG_TOP  = 4'h0;
   localparam logic [AW-1:0] ADDR_FLAG_SW   = 4'h1;
   localparam logic [AW-1:0] ADDR_FLAG_LN   = 4'h2;
   localparam logic [AW-1:0] ADDR_MASK_TOP  = 4'h3;
   localparam logic [AW-1:0] ADDR_MASK_SW   = 4'h4;
   localparam logic [AW-1:0] ADDR_MASK_LN   = 4'h5;
   localparam logic [AW-1:0] ADDR_STATE_TOP = 4'h6;
   localparam logic [AW-1:0] ADDR_STATE_SW  = 4'h7;
   localparam logic [AW-1:0] ADDR_STATE_LN  = 4'h8;
   localparam logic [AW-1:0] ADDR_CTRL      = 4'h9;
   localparam logic [AW-1:0] ADDR_RESET     = 4'hA;

   // Top flag, mask and state bit positions
   localparam int B_HOT   = 0;
   localparam int B_HEAT  = 1;
   localparam int B_OVV   = 2;
   localparam int B_OKDROP = 3;
   localparam int B_SYNC  = 4;
   localparam int B_MEAS  = 5;
   localparam int B_RST   = 6;
   localparam int B_SUMSW = 6;
   localparam int B_SUMLN = 7;
   // Control register bit positions
   localparam int B_GPOA  = 4;
   localparam int B_GPOB  = 5;
   localparam int B_POL   = 6;
   localparam int B_DET   = 7;

   // Writable top mask bits; the two shutdown flags are unmaskable
   localparam logic [6:0] TOP_MASK_WR = 7'h39;
   localparam logic [6:0] TOP_MASK_RST = 7'h00;
   localparam logic [5:0] REG_MASK_RST = 6'h00;
   localparam logic [7:0] CTRL_RST     = 8'h00;

   typedef enum {ST_OFF, ST_LOAD, ST_RUN} pfi_state_e;

   typedef struct packed {
      logic [1:0] sw_ilim;
      logic [1:0] ln_ilim;
      logic [1:0] sw_low;
      logic [1:0] ln_low;
      logic [1:0] sw_pg;
      logic [1:0] ln_pg;
      logic       hot_warn;
      logic       overheat;
      logic       overvolt;
      logic       volts_ok;
      logic       ext_clk;
      logic       meas_done;
      logic       uvlo;
   } pfi_analog_s;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } pfi_bus_s;
endpackage

// ===== bench/pfi_host_model.sv
// Host processor model: master on the plain register port.
// Assumes one clock; it launches strobes just after a rising edge.
`timescale 1ns/100ps
module pfi_host_model
   import pfi_pkg::*;
(
   // Clock
   input  wire logic          clock_i,
   // Register port
   output pfi_bus_s           bus_o,
   input  wire logic [DW-1:0] rdata_i
);
   initial bus_o = '0;

   // Idle lines show the inverse of the last value, never a stale copy
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clock_i);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
      @(posedge clock_i);
      bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      bus_o <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
      @(negedge clock_i);
      q = rdata_i;
   endtask
endmodule

// ===== bench/pfi_irq_ctrl_bench.sv
// Self-checking bench for the power-fault interrupt logic.
// Assumes the host model as master and a shortened short-circuit count.
`timescale 1ns/100ps
module pfi_irq_ctrl_bench
   import pfi_pkg::*;
;
   localparam int SC = 20;
   logic          clock_i;
   logic          rst_i;
   pfi_bus_s      bus;
   logic [DW-1:0] rdata;
   pfi_analog_s   an;
   logic          otp;
   logic          irq_n;
   logic [3:0]    en;
   logic          gpa;
   logic          gpb;
   logic          pin;
   int            err_count;
   int            n_tests;
   int            ix;
   logic [DW-1:0] q;
   logic [DW-1:0] mf [3];

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   pfi_host_model host (.clock_i(clock_i), .bus_o(bus), .rdata_i(rdata));

   pfi_irq_ctrl #(.SHORT_CYCLES(SC)) DUT (
      .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .analog_i(an),
      .otp_reset_mask_i(otp), .irq_line_n_o(irq_n), .reg_enable_o(en),
      .general_output_a_o(gpa), .general_output_b_o(gpb), .power_ok_pin_o(pin));

   task automatic chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
      host.rd(a, q);
      n_tests++;
      if (q !== e) begin
         err_count++;
         $display("mismatch at %0t: reg %h read %h want %h", $time, a, q, e);
      end
   endtask

   task automatic cv(input logic [7:0] got, input logic [7:0] e, input string m);
      n_tests++;
      if (got !== e) begin
         err_count++;
         $display("mismatch at %0t: %s is %h want %h", $time, m, got, e);
      end
   endtask

   // Filter takes 3-4 cycles, then flag and line one edge each
   task automatic st;
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   task automatic wc(input logic [AW-1:0] a, input logic [DW-1:0] d);
      host.wr(a, d);
      st;
   endtask

   task automatic rst_pulse;
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      st;
   endtask

   // One selector for every analog indication
   task automatic seta(input int k, input int g, input int i, input logic v);
      @(posedge clock_i);
      case (k * 2 + g)
         0: an.sw_ilim[i] <= v;
         1: an.ln_ilim[i] <= v;
         2: an.sw_low[i] <= v;
         3: an.ln_low[i] <= v;
         4: an.sw_pg[i] <= v;
         5: an.ln_pg[i] <= v;
         6: an.hot_warn <= v;
         8: an.overheat <= v;
         10: an.overvolt <= v;
         12: an.volts_ok <= v;
         14: an.ext_clk <= v;
         16: an.meas_done <= v;
         default: an.uvlo <= v;
      endcase
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test;
   end

   initial begin
      rst_i = 1'b1;
      an = '0;
      otp = 1'b0;
      err_count = 0;
      n_tests = 0;
      void'($urandom(32'h14b4d8db));
      rst_pulse;
      chk(ADDR_FLAG_TOP, 8'h40);
      cv(8'(irq_n), 8'h00, "irq");
      chk(ADDR_STATE_TOP, 8'h00);
      wc(ADDR_MASK_TOP, 8'hFF);
      chk(ADDR_MASK_TOP, 8'h39);
      wc(ADDR_MASK_TOP, 8'h00);
      wc(ADDR_FLAG_TOP, 8'h40);
      chk(ADDR_FLAG_TOP, 8'h00);
      cv(8'(irq_n), 8'h01, "irq");
      $display("test reset done");
      for (logic [AW-1:0] g = 4'h0; g < 4'h2; g++) begin
         ix = $urandom_range(1, 0);
         mf[g + 1] = 8'h01 << ix;
         seta(0, g, ix, 1'b1);
         st;
         chk(ADDR_FLAG_SW + g, mf[g + 1]);
         chk(ADDR_STATE_SW + g, 8'h01 << ix);
         chk(ADDR_STATE_TOP, 8'h40 << g);
         cv(8'(irq_n), 8'h00, "irq");
         wc(ADDR_FLAG_SW + g, mf[g + 1]);
         chk(ADDR_FLAG_SW + g, mf[g + 1]);
         seta(0, g, ix, 1'b0);
         st;
         wc(ADDR_FLAG_SW + g, mf[g + 1]);
         chk(ADDR_FLAG_SW + g, 8'h00);
         cv(8'(irq_n), 8'h01, "irq");
         wc(ADDR_MASK_SW + g, mf[g + 1]);
         seta(0, g, ix, 1'b1);
         st;
         chk(ADDR_FLAG_SW + g, mf[g + 1]);
         cv(8'(irq_n), 8'h01, "irq");
         seta(0, g, ix, 1'b0);
         st;
         wc(ADDR_FLAG_SW + g, mf[g + 1]);
         wc(ADDR_MASK_SW + g, 8'h00);
         wc(ADDR_CTRL, 8'h0F);
         seta(1, g, ix, 1'b1);
         repeat (SC + 10) @(posedge clock_i);
         @(negedge clock_i);
         cv(8'(en), 8'h0F & ~(8'h01 << (2 * g + ix)), "enables");
         chk(ADDR_FLAG_SW + g, 8'h04 << ix);
         cv(8'(irq_n), 8'h00, "irq");
         seta(1, g, ix, 1'b0);
         wc(ADDR_FLAG_SW + g, 8'h04 << ix);
         chk(ADDR_FLAG_SW + g, 8'h00);
         wc(ADDR_CTRL, 8'h00);
         wc(ADDR_MASK_SW + g, 8'h04 << ix);
         seta(2, g, ix, 1'b1);
         st;
         chk(ADDR_FLAG_SW + g, 8'h10 << ix);
         chk(ADDR_STATE_SW + g, 8'h04 << ix);
         cv(8'(irq_n), 8'h01, "irq");
         wc(ADDR_FLAG_SW + g, 8'h10 << ix);
         seta(2, g, ix, 1'b0);
         st;
         chk(ADDR_FLAG_SW + g, 8'h10 << ix);
         cv(8'(irq_n), 8'h00, "irq");
         wc(ADDR_FLAG_SW + g, 8'h10 << ix);
         wc(ADDR_MASK_SW + g, 8'h00);
         $display("test regulator group %0d done", g);
      end
      for (int k = 0; k < 3; k++) begin
         wc(ADDR_CTRL, 8'h3F);
         seta(3 + k, 0, 0, 1'b1);
         st;
         chk(ADDR_FLAG_TOP, 8'h01 << k);
         chk(ADDR_STATE_TOP, 8'h01 << k);
         cv(8'(irq_n), 8'h00, "irq");
         cv({2'b00, gpb, gpa, en}, (k == 0) ? 8'h3F : 8'h00, "outputs");
         wc(ADDR_FLAG_TOP, 8'h01 << k);
         chk(ADDR_FLAG_TOP, 8'h01 << k);
         seta(3 + k, 0, 0, 1'b0);
         st;
         wc(ADDR_FLAG_TOP, 8'h01 << k);
         chk(ADDR_FLAG_TOP, 8'h00);
         cv(8'(irq_n), 8'h01, "irq");
      end
      wc(ADDR_CTRL, 8'h00);
      $display("test thermal and supply done");
      seta(6, 0, 0, 1'b1);
      st;
      chk(ADDR_STATE_TOP, 8'h08);
      cv(8'(pin), 8'h01, "pin");
      wc(ADDR_CTRL, 8'h40);
      cv(8'(pin), 8'h00, "pin");
      chk(ADDR_STATE_TOP, 8'h08);
      seta(6, 0, 0, 1'b0);
      st;
      chk(ADDR_FLAG_TOP, 8'h08);
      cv(8'(irq_n), 8'h00, "irq");
      wc(ADDR_FLAG_TOP, 8'h08);
      wc(ADDR_CTRL, 8'h80);
      chk(ADDR_FLAG_TOP, 8'h10);
      wc(ADDR_FLAG_TOP, 8'h10);
      seta(7, 0, 0, 1'b1);
      st;
      chk(ADDR_FLAG_TOP, 8'h10);
      chk(ADDR_STATE_TOP, 8'h10);
      wc(ADDR_FLAG_TOP, 8'h10);
      wc(ADDR_CTRL, 8'h00);
      seta(7, 0, 0, 1'b0);
      seta(8, 0, 0, 1'b1);
      st;
      seta(8, 0, 0, 1'b0);
      st;
      chk(ADDR_FLAG_TOP, 8'h20);
      cv(8'(irq_n), 8'h00, "irq");
      wc(ADDR_MASK_TOP, 8'h20);
      cv(8'(irq_n), 8'h01, "irq");
      wc(ADDR_MASK_TOP, 8'h00);
      $display("test information flags done");
      wc(ADDR_CTRL, 8'h0F);
      seta(9, 0, 0, 1'b1);
      st;
      cv({4'h0, en}, 8'h00, "enables");
      cv(8'(irq_n), 8'h01, "irq");
      seta(9, 0, 0, 1'b0);
      st;
      chk(ADDR_FLAG_TOP, 8'h40);
      chk(ADDR_CTRL, 8'h00);
      wc(ADDR_FLAG_TOP, 8'h40);
      $display("test undervoltage done");
      @(posedge clock_i);
      otp <= 1'b1;
      rst_pulse;
      chk(ADDR_FLAG_TOP, 8'h00);
      wc(ADDR_MASK_TOP, 8'h00);
      chk(ADDR_MASK_TOP, 8'h40);
      wc(ADDR_RESET, 8'h01);
      chk(ADDR_FLAG_TOP, 8'h00);
      cv(8'(irq_n), 8'h01, "irq");
      @(posedge clock_i);
      otp <= 1'b0;
      wc(ADDR_RESET, 8'h01);
      chk(ADDR_FLAG_TOP, 8'h40);
      cv(8'(irq_n), 8'h00, "irq");
      $display("test reset mask done");
      end_of_test;
   end
endmodule
